/* File: common/timer0_defines.svh */
// Offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER0_DEFINES_SVH
`define TIMER0_DEFINES_SVH

`define T0_OFF_COUNT   4'h0
`define T0_OFF_OPTION  4'h4
`define T0_OFF_IRQCTL  4'h8

`define T0_BIT_SRC     5
`define T0_BIT_EDGE    4
`define T0_BIT_PSA     3
`define T0_BIT_IE      5
`define T0_BIT_FLAG    2

`define T0_OPTION_RST  6'h3f
`define T0_COUNT_RST   8'h00

`define T0_TOSC_NS     20
`define T0_INHIBIT_CYC 2'h2
`define T0_LAST_PHASE  2'h3

`endif

/* File: common/timer0_pkg.sv */
// Types shared by the timer files
package timer0_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    typedef logic [7:0] count_t;

endpackage

/* File: logic/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once the last two stages agree
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            level <= 1'b0;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end
endmodule

/* File: logic/timer0_top.sv */
// Timer/counter with shared prescaler behind an Avalon-MM slave
`timescale 1ns/10ps
`include "timer0_defines.svh"
module timer0_top #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    input  wire logic              ext_count_pin,
    input  wire logic              sleep,
    input  wire logic              wdt_tick,
    input  wire logic              watchdog_clear_op,
    output logic                   wdt_timeout,
    output logic                   irq
);

    if (ADDR_W < 4 || DATA_W != 32) begin : g_bad_param
        $error("timer0_top needs ADDR_W >= 4 and DATA_W == 32");
    end

    timer0_pkg::bus_state_e bus_q;
    timer0_pkg::count_t     count_register_q;
    logic [5:0]             option_q;
    logic                   overflow_irq_enable_q;
    logic                   overflow_flag_q;
    timer0_pkg::count_t     pres_q;
    logic [1:0]             phase_q;
    logic [1:0]             inhibit_q;
    logic                   pol_q;
    logic                   samp_q;
    logic                   ext_level;

    logic                   req;
    logic                   take;
    logic                   wr_take;
    logic                   wr_count;
    logic                   wr_option;
    logic                   wr_irqctl;
    logic                   source_select_bit;
    logic                   edge_select_bit;
    logic                   prescaler_assign_bit;
    logic [2:0]             prescale_ratio_field;
    logic                   tick;
    logic                   sample_pt;
    logic                   pol;
    logic                   pol_rise;
    logic                   pre_out;
    logic [7:0]             tmask;
    logic [7:0]             wmask;
    logic                   int_inc;
    logic                   ext_inc;
    logic                   inc;
    logic                   ovf_ev;

    assign source_select_bit    = option_q[`T0_BIT_SRC];
    assign edge_select_bit      = option_q[`T0_BIT_EDGE];
    assign prescaler_assign_bit = option_q[`T0_BIT_PSA];
    assign prescale_ratio_field = option_q[2:0];

    // Avalon slave: one wait cycle, then the answer
    assign req         = read | write;
    assign waitrequest = req & (bus_q == timer0_pkg::BUS_IDLE);
    assign take        = req & (bus_q == timer0_pkg::BUS_ACK);
    assign wr_take     = take & write & byteenable[0];
    assign wr_count    = wr_take & (address == `T0_OFF_COUNT);
    assign wr_option   = wr_take & (address == `T0_OFF_OPTION);
    assign wr_irqctl   = wr_take & (address == `T0_OFF_IRQCTL);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_q <= timer0_pkg::BUS_IDLE;
        end else begin
            unique case (bus_q)
                timer0_pkg::BUS_IDLE: begin
                    if (req) begin
                        bus_q <= timer0_pkg::BUS_ACK;
                    end
                end
                timer0_pkg::BUS_ACK: begin
                    bus_q <= timer0_pkg::BUS_IDLE;
                end
                default: begin
                    bus_q <= timer0_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read data is captured during the wait cycle; the prescaler is not mapped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            readdata <= '0;
        end else if (read && bus_q == timer0_pkg::BUS_IDLE) begin
            unique case (address)
                `T0_OFF_COUNT: begin
                    readdata <= {24'h0, count_register_q};
                end
                `T0_OFF_OPTION: begin
                    readdata <= {26'h0, option_q};
                end
                `T0_OFF_IRQCTL: begin
                    readdata <= {26'h0, overflow_irq_enable_q, 2'h0,
                                 overflow_flag_q, 2'h0};
                end
                default: begin
                    readdata <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            option_q <= `T0_OPTION_RST;
        end else if (wr_option) begin
            option_q <= writedata[5:0];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            overflow_irq_enable_q <= 1'b0;
        end else if (wr_irqctl) begin
            overflow_irq_enable_q <= writedata[`T0_BIT_IE];
        end
    end

    // Instruction cycle of four oscillator phases
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign tick      = (phase_q == `T0_LAST_PHASE);
    assign sample_pt = phase_q[0];

    pin_sync pin_sync_i (
        .mclk  (mclk),
        .reset (reset),
        .pin   (ext_count_pin),
        .level (ext_level)
    );

    // Falling edges are turned into rising ones by inversion
    assign pol      = ext_level ^ edge_select_bit;
    assign pol_rise = pol & ~pol_q;

    // Reset values match pin low under the reset option, so no false edge follows reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pol_q <= 1'b1;
        end else begin
            pol_q <= pol;
        end
    end

    // Counter divide is 2^(n+1), watchdog postscale is 2^n
    assign tmask = 8'((9'h2 << prescale_ratio_field) - 9'h1);
    assign wmask = 8'((9'h1 << prescale_ratio_field) - 9'h1);

    // Prescaler owned by exactly one user at a time
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pres_q <= 8'h00;
        end else if (!prescaler_assign_bit) begin
            if (wr_count) begin
                pres_q <= 8'h00;
            end else if (!sleep) begin
                if (source_select_bit ? pol_rise : tick) begin
                    pres_q <= pres_q + 8'h01;
                end
            end
        end else begin
            if (watchdog_clear_op) begin
                pres_q <= 8'h00;
            end else if (wdt_tick) begin
                pres_q <= pres_q + 8'h01;
            end
        end
    end

    // Prescaler output bit is a symmetric divided copy of the pin, or pol itself when the watchdog owns the prescaler
    assign pre_out = prescaler_assign_bit ? pol
                   : pres_q[prescale_ratio_field];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            samp_q <= 1'b1;
        end else if (sample_pt) begin
            samp_q <= pre_out;
        end
    end

    assign ext_inc = sample_pt & pre_out & ~samp_q;
    assign int_inc = tick & (prescaler_assign_bit
                   | ((pres_q & tmask) == tmask));
    assign inc     = (source_select_bit ? ext_inc : int_inc)
                   & (inhibit_q == 2'h0) & ~sleep;
    assign ovf_ev  = inc & (count_register_q == 8'hff);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            inhibit_q <= 2'h0;
        end else if (wr_count) begin
            inhibit_q <= `T0_INHIBIT_CYC;
        end else if (tick && inhibit_q != 2'h0) begin
            inhibit_q <= inhibit_q - 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_register_q <= `T0_COUNT_RST;
        end else if (wr_count) begin
            count_register_q <= writedata[7:0];
        end else if (inc) begin
            count_register_q <= count_register_q + 8'h01;
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            overflow_flag_q <= 1'b0;
        end else if (ovf_ev) begin
            overflow_flag_q <= 1'b1;
        end else if (wr_irqctl) begin
            overflow_flag_q <= writedata[`T0_BIT_FLAG];
        end
    end

    assign irq = overflow_flag_q & overflow_irq_enable_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wdt_timeout <= 1'b0;
        end else if (prescaler_assign_bit) begin
            wdt_timeout <= wdt_tick & ~watchdog_clear_op
                         & ((pres_q & wmask) == wmask);
        end else begin
            wdt_timeout <= wdt_tick;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_wrap;
        inc && !wr_count && count_register_q == 8'hff
            |=> count_register_q == 8'h00 && overflow_flag_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap failed");

    property p_irq;
        $rose(overflow_flag_q) && overflow_irq_enable_q |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_flag_hold;
        overflow_flag_q && !wr_irqctl |=> overflow_flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

    property p_inhibit;
        wr_count |=> !inc [*5];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("count not held");

    property p_pres_clr;
        wr_count && !prescaler_assign_bit |=> pres_q == 8'h00;
    endproperty
    a_pres_clr: assert property (p_pres_clr) else $error("prescaler kept");

    property p_wdt_clr;
        watchdog_clear_op && prescaler_assign_bit && !wr_option
            |=> pres_q == 8'h00;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("wdt clear missed");

    property p_one_to_one;
        tick && prescaler_assign_bit && !source_select_bit && !sleep
            && inhibit_q == 2'h0 && !wr_count && !wr_option
            |=> count_register_q == 8'($past(count_register_q) + 8'h01);
    endproperty
    a_one_to_one: assert property (p_one_to_one) else $error("not 1:1");

    property p_sleep;
        sleep && !wr_count |=> $stable(count_register_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("counted in sleep");

    property p_set_wins;
        ovf_ev && wr_irqctl |=> overflow_flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overflow lost");

    property p_unscaled_wdt;
        !prescaler_assign_bit && wdt_tick && !wr_option |=> wdt_timeout;
    endproperty
    a_unscaled_wdt: assert property (p_unscaled_wdt) else $error("wdt scaled");

    property p_sample;
        !sample_pt |=> $stable(samp_q);
    endproperty
    a_sample: assert property (p_sample) else $error("sampled off phase");

    property p_timer_div2;
        tick && !prescaler_assign_bit && !source_select_bit
            && prescale_ratio_field == 3'h0 && inc
            |-> ##4 !inc ##4 1'b1;
    endproperty
    a_timer_div2: assert property (p_timer_div2) else $error("1:2 broken");

    property p_answer;
        req && bus_q == timer0_pkg::BUS_IDLE |=> !waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");

    property p_pin_delay;
        $rose(pol) && source_select_bit && prescaler_assign_bit
            && inhibit_q == 2'h0 && !sleep && !wr_count && !wr_option
            |-> ##[0:1] inc;
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("pin edge too slow");

    property p_count_wr;
        wr_count |=> count_register_q == $past(writedata[7:0]);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost");

    property p_option_wr;
        wr_option |=> option_q == $past(writedata[5:0]);
    endproperty
    a_option_wr: assert property (p_option_wr) else $error("option write lost");

endmodule

/* File: verif/pin_source.sv */
// Behavioural pulse source on the external count input
`timescale 1ns/10ps
module pin_source (
    output logic pin
);
    // Stands still between bursts; 160 ns period inside a burst
    initial pin = 1'b0;

    task automatic set_level(input logic v);
        #37 pin = v;
    endtask

    task automatic drive_pulses(input int n);
        #7;
        repeat (n) begin
            #80 pin = 1'b1;
            #80 pin = 1'b0;
        end
    endtask
endmodule

/* File: verif/timer0_counter_with_shared_prescaler_bench.sv */
// Self-checking bench for the timer with shared prescaler
`timescale 1ns/10ps
`include "timer0_defines.svh"
module timer0_counter_with_shared_prescaler_bench;
    logic        mclk;
    logic        reset;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        pin;
    logic        sleep;
    logic        wdt_tick;
    logic        wdt_clr;
    logic        wdt_timeout;
    logic        irq;
    int          failures;
    int          cmp_count;
    int          wdt_seen = 0;
    logic [31:0] q;

    timer0_top timer0_top_i (
        .mclk              (mclk),
        .reset             (reset),
        .address           (address),
        .read              (read),
        .write             (write),
        .writedata         (writedata),
        .byteenable        (byteenable),
        .readdata          (readdata),
        .waitrequest       (waitrequest),
        .ext_count_pin     (pin),
        .sleep             (sleep),
        .wdt_tick          (wdt_tick),
        .watchdog_clear_op (wdt_clr),
        .wdt_timeout       (wdt_timeout),
        .irq               (irq)
    );

    pin_source pin_source_i (
        .pin (pin)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (wdt_timeout === 1'b1) wdt_seen <= wdt_seen + 1;
    end

    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] r);
        logic w;
        @(posedge mclk);
        address    <= a;
        writedata  <= {24'h000000, d};
        byteenable <= be;
        read       <= !wr;
        write      <= wr;
        do begin
            @(posedge mclk);
            w = waitrequest;
            r = readdata;
        end while (w !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] r);
        bus(1'b0, a, 8'h00, 4'hf, r);
    endtask

    // Count advance between two reads 64 cycles apart
    task automatic delta(output logic [7:0] d);
        logic [31:0] c1;
        logic [31:0] c2;
        rd_reg(`T0_OFF_COUNT, c1);
        repeat (61) @(posedge mclk);
        rd_reg(`T0_OFF_COUNT, c2);
        d = c2[7:0] - c1[7:0];
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            wdt_tick <= 1'b1;
            @(posedge mclk);
            wdt_tick <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask

    task automatic clr_pulse();
        @(posedge mclk);
        wdt_clr <= 1'b1;
        @(posedge mclk);
        wdt_clr <= 1'b0;
    endtask

    task automatic test_reset();
        rd_reg(`T0_OFF_COUNT, q);
        check("count", q, 32'h00000000);
        rd_reg(`T0_OFF_OPTION, q);
        check("option", q, 32'h0000003f);
        rd_reg(`T0_OFF_IRQCTL, q);
        check("irqctl", q, 32'h00000000);
        rd_reg(4'hc, q);
        check("unmapped", q, 32'h00000000);
        bus(1'b1, `T0_OFF_OPTION, 8'h00, 4'he, q);
        rd_reg(`T0_OFF_OPTION, q);
        check("option_be", q, 32'h0000003f);
    endtask

    task automatic test_timer();
        logic [7:0] d;
        wr_reg(`T0_OFF_OPTION, 8'h08);
        delta(d);
        check("rate_1to1", d, 8'h10);
        wr_reg(`T0_OFF_COUNT, 8'h55);
        rd_reg(`T0_OFF_COUNT, q);
        check("after_write", q, 32'h00000055);
        sleep <= 1'b1;
        delta(d);
        check("sleep", d, 8'h00);
        sleep <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            wr_reg(`T0_OFF_OPTION, 8'(n));
            delta(d);
            check("ratio", d, 8'(16 >> (n + 1)));
        end
    endtask

    task automatic test_overflow();
        wr_reg(`T0_OFF_OPTION, 8'h08);
        wr_reg(`T0_OFF_COUNT, 8'hff);
        repeat (20) @(posedge mclk);
        rd_reg(`T0_OFF_IRQCTL, q);
        check("flag_set", q, 32'h00000004);
        check("irq_masked", irq, 1'b0);
        wr_reg(`T0_OFF_IRQCTL, 8'h24);
        @(negedge mclk);
        check("irq_on", irq, 1'b1);
        repeat (30) @(posedge mclk);
        rd_reg(`T0_OFF_IRQCTL, q);
        check("flag_held", q, 32'h00000024);
        wr_reg(`T0_OFF_IRQCTL, 8'h20);
        @(negedge mclk);
        check("irq_off", irq, 1'b0);
    endtask

    task automatic test_pin();
        logic [31:0] c1;
        logic [7:0]  opt [3] = '{8'h28, 8'h20, 8'h22};
        int          np [3]  = '{8, 8, 16};
        logic [7:0]  ex [3]  = '{8'h08, 8'h04, 8'h02};
        for (int e = 0; e < 2; e++) begin
            wr_reg(`T0_OFF_OPTION, 8'h28 | 8'(e << 4));
            // Flipping the edge select alone may add one count; let it settle first
            repeat (8) @(posedge mclk);
            rd_reg(`T0_OFF_COUNT, c1);
            pin_source_i.set_level(1'b1);
            repeat (20) @(posedge mclk);
            rd_reg(`T0_OFF_COUNT, q);
            check("rise_step", q[7:0] - c1[7:0], 8'(e == 0));
            pin_source_i.set_level(1'b0);
            repeat (20) @(posedge mclk);
            rd_reg(`T0_OFF_COUNT, c1);
            check("fall_step", c1[7:0] - q[7:0], 8'(e == 1));
        end
        for (int i = 0; i < 3; i++) begin
            wr_reg(`T0_OFF_OPTION, opt[i]);
            wr_reg(`T0_OFF_COUNT, 8'h00);
            repeat (10) @(posedge mclk);
            pin_source_i.drive_pulses(np[i]);
            repeat (20) @(posedge mclk);
            rd_reg(`T0_OFF_COUNT, q);
            check("pin_count", q, {24'h000000, ex[i]});
        end
    endtask

    task automatic test_wdt();
        int s;
        wr_reg(`T0_OFF_COUNT, 8'h00);
        wr_reg(`T0_OFF_OPTION, 8'h2a);
        clr_pulse();
        wr_reg(`T0_OFF_OPTION, 8'h0a);
        s = wdt_seen;
        ticks(16);
        check("wdt_div4", 32'(wdt_seen - s), 32'h00000004);
        wr_reg(`T0_OFF_OPTION, 8'h0b);
        clr_pulse();
        ticks(4);
        clr_pulse();
        s = wdt_seen;
        ticks(7);
        check("wdt_clear", 32'(wdt_seen - s), 32'h00000000);
        ticks(1);
        check("wdt_div8", 32'(wdt_seen - s), 32'h00000001);
        wr_reg(`T0_OFF_OPTION, 8'h02);
        s = wdt_seen;
        ticks(5);
        check("wdt_unscaled", 32'(wdt_seen - s), 32'h00000005);
    endtask

    initial begin
        failures   = 0;
        cmp_count  = 0;
        reset      = 1'b1;
        address    = 4'h0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h00000000;
        byteenable = 4'hf;
        sleep      = 1'b0;
        wdt_tick   = 1'b0;
        wdt_clr    = 1'b0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        test_reset();
        test_timer();
        test_overflow();
        test_pin();
        test_wdt();
        report_and_stop();
    end

    initial begin
        #1_500_000;
        failures++;
        report_and_stop();
    end
endmodule
